// ===== shared/dds_regs.svh
/*
 Constants of the disk drive operation sequencer: register offsets, geometry,
 field values, command codes and timing counts. Assumes a 50 MHz system clock
 and Avalon-MM word addressing, one offset per 32-bit register.
*/
// Functional notes
// RULE1 - Power-on pulse lasts 0.5 second
// RULE2 - Power-on pulse clears latched power faults
// RULE3 - Logic, spindle, amplifier held reset during pulse
// RULE4 - Fault at interval end: power down, keep resets
// RULE5 - No fault: release resets, start self-test
// RULE6 - Self-test at power-up and on command
// RULE7 - Hard reset disables servo, write-protects channel
// RULE8 - Display shows descending stage code six to one
// RULE9 - Seek test all tracks, retry once, halt; a commanded test steps only from the current cylinder up
// RULE10 - Port test writes head/flow, reads back
// RULE11 - Encoder and RWR tests at cylinder 786, sixteen heads
// RULE12 - Success lights ready, blanks display
// RULE13 - Seek loads remaining count and direction
// RULE14 - Positioner decrements remaining count per track
// RULE15 - Count of one switches coarse to fine
// RULE16 - Coarse checks each quarter track, fine continuously
// RULE17 - Next crossing verifies position, then track-follow
// RULE18 - Setup packet range-checked, then seek begins
// RULE19 - Select head, wait sector minus offset, interrupt
// RULE20 - Data mode answer, then control word written
// RULE21 - Controller skips sectors with wrong header
// RULE22 - 523 bytes per sector passed to encoder
// RULE23 - Command mode return stops processor, idles flow
// RULE24 - Sector counter counts pulses, clears on index
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH
// ****************
// Timing
// ****************
`define DDS_CLK_HZ 50000000
`define DDS_PON_MS 500
`define DDS_PON_CYC ((`DDS_CLK_HZ / 1000) * `DDS_PON_MS)
// ****************
// Register offsets
// ****************
`define DDS_OFS_STATUS 4'h0
`define DDS_OFS_CMD 4'h1
`define DDS_OFS_PACKET 4'h2
`define DDS_OFS_OFFSET 4'h3
`define DDS_OFS_TRACK 4'h4
`define DDS_OFS_SECTOR 4'h5
// ****************
// Geometry and field values
// ****************
`define DDS_MAX_CYL 11'h7FF
`define DDS_TEST_CYL 11'h312
`define DDS_NUM_HEADS 5'h10
`define DDS_MAX_SECTOR 6'h3F
`define DDS_SECTOR_BYTES 10'h20B
`define DDS_CMD_SEEK 3'h1
`define DDS_CMD_SELFTEST 3'h2
`define DDS_CMD_WRITE 3'h3
`define DDS_DISP_BLANK 4'hF
`endif

// ===== shared/dds_pkg.sv
/*
 Types of the disk drive operation sequencer. Assumes nothing else.
*/
package dds_pkg;
   typedef enum logic [3:0] {
      DDS_OFF, DDS_PON, DDS_DOWN, DDS_T_SERVO, DDS_T_SEEK, DDS_T_PORT,
      DDS_T_ROT, DDS_T_ENC, DDS_T_RWR, DDS_HALT, DDS_IDLE, DDS_SEEK,
      DDS_WAIT_SEC, DDS_WAIT_MODE, DDS_XFER
   } dds_state_e;
   typedef enum logic [1:0] {
      DDS_TRACK_FOLLOW, DDS_COARSE, DDS_FINE
   } dds_seek_mode_e;
endpackage

// ===== rtl/dds_sequencer.sv
/*
 Drive-side operation sequencer: power-on interval, self-test stages,
 distance-to-go seek control and write transfer start.
 Assumes positioner, supply monitors and controller bus signals are
 synchronous to sys_clk; registers on Avalon-MM with waitrequest.
*/
// Added by the designer: the register offsets and the Avalon-MM register port.
`include "dds_regs.svh"
module dds_sequencer
   import dds_pkg::*;
#(
   parameter int PON_CYCLES = `DDS_PON_CYC
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic power_switch,
   input wire logic supply_fault,
   output logic power_on_pulse,
   output logic power_down,
   output logic hard_reset,
   output logic servo_disable,
   output logic write_protect,
   output logic [3:0] display_code,
   output logic ready_led,
   input wire logic track_cross,
   input wire logic quarter_track,
   input wire logic [10:0] head_position,
   input wire logic test_fail,
   output logic [1:0] seek_mode,
   output logic seek_dir,
   output logic [10:0] remaining_track_count,
   output logic pos_check,
   output logic seek_done,
   input wire logic sector_pulse,
   input wire logic index_pulse,
   output logic [3:0] head_select,
   output logic ctrl_irq,
   input wire logic bus_data_mode,
   output logic rw_ctrl_write,
   output logic rw_active,
   input wire logic ctrl_byte_valid,
   input wire logic [7:0] ctrl_byte,
   output logic ctrl_byte_ready,
   output logic enc_valid,
   output logic [7:0] enc_data,
   input wire logic enc_ready,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // ****************
   // Declarations
   // ****************
   dds_state_e state;
   dds_state_e next_state;
   logic [31:0] pon_cnt;
   logic fault_latch;
   logic [10:0] abs_track;
   logic [10:0] target_cyl;
   logic [2:0] pkt_op;
   logic [3:0] pkt_head;
   logic [5:0] pkt_sector;
   logic [5:0] sec_offset;
   logic [5:0] sector_count;
   logic pkt_ok;
   logic seek_req;
   logic selftest_req;
   logic write_req;
   logic seek_busy;
   logic seek_fail;
   logic retry;
   logic [4:0] head_idx;
   logic [9:0] byte_cnt;
   logic port_match;
   logic bus_ack;
   logic wr_cmd;

   // ****************
   // Avalon slave
   // ****************
   // One wait cycle per access keeps read data registered
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         bus_ack <= 1'b0;
      else
         bus_ack <= (avs_read | avs_write) & ~bus_ack;
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
   assign wr_cmd = avs_write & ~avs_waitrequest;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read & ~bus_ack)
      begin
         unique case (avs_address)
            `DDS_OFS_STATUS: avs_readdata <= {20'h00000, ready_led,
               fault_latch, seek_busy, pkt_ok, 4'h0, state};
            `DDS_OFS_PACKET: avs_readdata <= {7'h00, pkt_op, pkt_head,
               pkt_sector, 1'b0, target_cyl};
            `DDS_OFS_OFFSET: avs_readdata <= {26'h0000000, sec_offset};
            `DDS_OFS_TRACK: avs_readdata <= {21'h000000, abs_track};
            `DDS_OFS_SECTOR: avs_readdata <= {6'h00, byte_cnt, 10'h000,
               sector_count};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Command strobes and packet
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         seek_req <= 1'b0;
         selftest_req <= 1'b0;
         write_req <= 1'b0;
         pkt_op <= 3'h0;
         pkt_head <= 4'h0;
         pkt_sector <= 6'h00;
         target_cyl <= 11'h000;
         sec_offset <= 6'h00;
      end
      else
      begin
         seek_req <= 1'b0;
         selftest_req <= 1'b0;
         write_req <= 1'b0;
         if (wr_cmd && avs_address == `DDS_OFS_CMD)
         begin
            seek_req <= avs_writedata[2:0] == `DDS_CMD_SEEK;
            selftest_req <= avs_writedata[2:0] == `DDS_CMD_SELFTEST; // RULE6
            write_req <= avs_writedata[2:0] == `DDS_CMD_WRITE;
         end
         if (wr_cmd && avs_address == `DDS_OFS_PACKET)
         begin
            target_cyl <= avs_writedata[10:0];
            pkt_sector <= avs_writedata[17:12];
            pkt_head <= avs_writedata[21:18];
            pkt_op <= avs_writedata[24:22];
         end
         if (wr_cmd && avs_address == `DDS_OFS_OFFSET)
            sec_offset <= avs_writedata[5:0];
      end
   end

   // Cylinder limit is the field width; head and sector fit by width
   assign pkt_ok = target_cyl <= `DDS_MAX_CYL
      && pkt_sector <= `DDS_MAX_SECTOR; // RULE18

   // ****************
   // Power-on interval
   // ****************
   always_ff @(posedge sys_clk)
   begin
      if (rst || state == DDS_OFF)
         pon_cnt <= 32'h0000_0000;
      else if (state == DDS_PON)
         pon_cnt <= pon_cnt + 32'h0000_0001; // RULE1
   end
   assign power_on_pulse = state == DDS_PON; // RULE1

   always_ff @(posedge sys_clk)
   begin
      if (rst || power_on_pulse)
         fault_latch <= 1'b0; // RULE2
      else if (supply_fault)
         fault_latch <= 1'b1;
   end

   assign hard_reset = state == DDS_OFF || state == DDS_PON
      || state == DDS_DOWN; // RULE3
   assign servo_disable = hard_reset; // RULE7
   assign write_protect = hard_reset || !rw_active; // RULE7
   assign power_down = state == DDS_DOWN; // RULE4

   // ****************
   // Sequencer
   // ****************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         state <= DDS_OFF;
      else
         state <= next_state;
   end

   assign port_match = head_select == pkt_head;

   always_comb
   begin
      next_state = state;
      unique case (state)
         DDS_OFF: if (power_switch) next_state = DDS_PON;
         DDS_PON:
            if (pon_cnt == PON_CYCLES - 1)
               next_state = (fault_latch | supply_fault) ? DDS_DOWN
                  : DDS_T_SERVO; // RULE4 RULE5
         DDS_DOWN: if (!power_switch) next_state = DDS_OFF;
         DDS_T_SERVO: next_state = test_fail ? DDS_HALT : DDS_T_SEEK;
         DDS_T_SEEK:
            if (!seek_busy && seek_done)
            begin
               if (abs_track == `DDS_MAX_CYL)
                  next_state = DDS_T_PORT;
            end
            else if (seek_fail && retry)
               next_state = DDS_HALT; // RULE9
         DDS_T_PORT: next_state = port_match ? DDS_T_ROT : DDS_HALT; // RULE10
         DDS_T_ROT: if (index_pulse) next_state = DDS_T_ENC;
         DDS_T_ENC:
            if (seek_done && abs_track == `DDS_TEST_CYL)
               next_state = DDS_T_RWR; // RULE11
         DDS_T_RWR:
            if (test_fail)
               next_state = DDS_HALT;
            else if (head_idx == `DDS_NUM_HEADS)
               next_state = DDS_IDLE; // RULE11 RULE12
         DDS_HALT: next_state = DDS_HALT;
         DDS_IDLE:
            if (selftest_req)
               next_state = DDS_T_SERVO; // RULE6
            else if ((seek_req || write_req) && pkt_ok)
               next_state = DDS_SEEK; // RULE18
         DDS_SEEK:
            if (seek_done)
               next_state = pkt_op == `DDS_CMD_WRITE ? DDS_WAIT_SEC
                  : DDS_IDLE;
         DDS_WAIT_SEC:
            if (sector_count == pkt_sector - sec_offset)
               next_state = DDS_WAIT_MODE; // RULE19
         DDS_WAIT_MODE: if (bus_data_mode) next_state = DDS_XFER; // RULE20
         DDS_XFER: if (!bus_data_mode) next_state = DDS_IDLE; // RULE23
         default: next_state = DDS_OFF;
      endcase
   end

   // Stage code on display
   always_comb
   begin
      unique case (state)
         DDS_T_SERVO: display_code = 4'h6; // RULE8
         DDS_T_SEEK: display_code = 4'h5;
         DDS_T_PORT: display_code = 4'h4;
         DDS_T_ROT: display_code = 4'h3;
         DDS_T_ENC: display_code = 4'h2;
         DDS_T_RWR: display_code = 4'h1;
         DDS_HALT: display_code = 4'hE;
         default: display_code = `DDS_DISP_BLANK; // RULE12
      endcase
   end
   assign ready_led = state >= DDS_IDLE; // RULE12

   // Seek test retry and head walk
   always_ff @(posedge sys_clk)
   begin
      if (rst || state != DDS_T_SEEK)
         retry <= 1'b0;
      else if (seek_fail)
         retry <= 1'b1; // RULE9
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst || state != DDS_T_RWR)
         head_idx <= 5'h00;
      else if (index_pulse)
         head_idx <= head_idx + 5'h01; // RULE11
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         head_select <= 4'h0;
      else if (state == DDS_T_RWR)
         head_select <= head_idx[3:0];
      else if (next_state == DDS_WAIT_SEC || state == DDS_T_SEEK)
         head_select <= pkt_head; // RULE10 RULE19
   end

   // ****************
   // Seek control
   // ****************
   logic seek_start;
   logic [10:0] seek_dest;
   assign seek_start = (state == DDS_IDLE && next_state == DDS_SEEK)
      || (state == DDS_T_SEEK && !seek_busy && !seek_done)
      || (state == DDS_T_ENC && !seek_busy && !seek_done);
   assign seek_dest = state == DDS_T_SEEK ? abs_track + 11'h001
      : state == DDS_T_ENC ? `DDS_TEST_CYL : target_cyl;
   assign pos_check = seek_mode == DDS_FINE
      || (seek_mode == DDS_COARSE && quarter_track); // RULE16

   always_ff @(posedge sys_clk)
   begin
      if (rst || hard_reset)
      begin
         seek_busy <= 1'b0;
         seek_done <= 1'b0;
         seek_fail <= 1'b0;
         seek_mode <= DDS_TRACK_FOLLOW;
         seek_dir <= 1'b0;
         remaining_track_count <= 11'h000;
         abs_track <= 11'h000;
      end
      else
      begin
         seek_done <= 1'b0;
         seek_fail <= 1'b0;
         if (seek_start && seek_dest == abs_track)
            seek_done <= 1'b1;
         else if (seek_start)
         begin
            seek_busy <= 1'b1;
            seek_dir <= seek_dest > abs_track; // RULE13
            remaining_track_count <= seek_dest > abs_track
               ? seek_dest - abs_track : abs_track - seek_dest; // RULE13
            seek_mode <= DDS_COARSE;
         end
         else if (seek_busy && track_cross)
         begin
            if (seek_mode == DDS_FINE)
            begin
               seek_busy <= 1'b0;
               seek_mode <= DDS_TRACK_FOLLOW; // RULE17
               if (head_position == seek_dest)
               begin
                  abs_track <= head_position;
                  seek_done <= 1'b1;
               end
               else
                  seek_fail <= 1'b1;
            end
            else
               remaining_track_count <= remaining_track_count
                  - 11'h001; // RULE14
         end
         else if (seek_busy && seek_mode == DDS_COARSE
            && remaining_track_count == 11'h001)
            seek_mode <= DDS_FINE; // RULE15
      end
   end

   // ****************
   // Sector counter
   // ****************
   always_ff @(posedge sys_clk)
   begin
      if (rst || index_pulse)
         sector_count <= 6'h00; // RULE24
      else if (sector_pulse)
         sector_count <= sector_count + 6'h01; // RULE24
   end

   // ****************
   // Write transfer
   // ****************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ctrl_irq <= 1'b0;
      else
         ctrl_irq <= state == DDS_WAIT_MODE; // RULE19
   end
   assign rw_ctrl_write = state == DDS_WAIT_MODE && bus_data_mode; // RULE20
   assign rw_active = state == DDS_XFER; // RULE23

   // Bytes pass through one register stage; the encoder throttles the controller
   assign ctrl_byte_ready = rw_active && (!enc_valid || enc_ready);
   always_ff @(posedge sys_clk)
   begin
      if (rst || !rw_active)
      begin
         enc_valid <= 1'b0;
         enc_data <= 8'h00;
         byte_cnt <= 10'h000;
      end
      else
      begin
         if (enc_ready)
            enc_valid <= 1'b0;
         if (ctrl_byte_valid && ctrl_byte_ready)
         begin
            enc_valid <= 1'b1;
            enc_data <= ctrl_byte; // RULE22
            byte_cnt <= byte_cnt == `DDS_SECTOR_BYTES - 10'h001 ? 10'h000
               : byte_cnt + 10'h001; // RULE22
         end
      end
   end

   // ****************
   // Assertions
   // ****************
   property p_reset_hold;
      @(posedge sys_clk) disable iff (rst)
      power_on_pulse |-> hard_reset && servo_disable && write_protect;
   endproperty
   a_reset_hold: assert property (p_reset_hold) // RULE3
      else $error("Reset not held during power-on");
   property p_fault_down;
      @(posedge sys_clk) disable iff (rst)
      state == DDS_PON && next_state == DDS_DOWN |=> power_down && hard_reset;
   endproperty
   a_fault_down: assert property (p_fault_down) // RULE4
      else $error("Fault did not power down");
   property p_release;
      @(posedge sys_clk) disable iff (rst)
      state == DDS_PON && next_state == DDS_T_SERVO
      |=> !hard_reset && display_code == 4'h6;
   endproperty
   a_release: assert property (p_release) // RULE5
      else $error("Resets not released into self-test");
   property p_fine;
      @(posedge sys_clk) disable iff (rst)
      seek_busy && seek_mode == DDS_COARSE && remaining_track_count == 11'h001
      && !track_cross && !seek_start |=> seek_mode == DDS_FINE;
   endproperty
   a_fine: assert property (p_fine) // RULE15
      else $error("No switch to fine seek at count one");
   property p_dec;
      @(posedge sys_clk) disable iff (rst)
      seek_busy && !hard_reset && seek_mode == DDS_COARSE && track_cross
      && !seek_start
      |=> remaining_track_count == $past(remaining_track_count) - 11'h001;
   endproperty
   a_dec: assert property (p_dec) // RULE14
      else $error("Remaining count not decremented");
   property p_ready;
      @(posedge sys_clk) disable iff (rst)
      ready_led |-> display_code == `DDS_DISP_BLANK;
   endproperty
   a_ready: assert property (p_ready) // RULE12
      else $error("Ready with display not blank");
   property p_ctl_word;
      @(posedge sys_clk) disable iff (rst)
      rw_ctrl_write |-> $past(ctrl_irq) && bus_data_mode ##1 rw_active;
   endproperty
   a_ctl_word: assert property (p_ctl_word) // RULE20
      else $error("Control word without data mode");
   property p_stop;
      @(posedge sys_clk) disable iff (rst)
      rw_active && !bus_data_mode |=> !rw_active && !enc_valid;
   endproperty
   a_stop: assert property (p_stop) // RULE23
      else $error("Processor not stopped on command mode");
   property p_index;
      @(posedge sys_clk) disable iff (rst)
      index_pulse |=> sector_count == 6'h00;
   endproperty
   a_index: assert property (p_index) // RULE24
      else $error("Sector counter not cleared by index");
   c_power_up: cover property (@(posedge sys_clk) state == DDS_IDLE);
   c_halt: cover property (@(posedge sys_clk) state == DDS_HALT);
   c_seek: cover property (@(posedge sys_clk) state == DDS_SEEK && seek_done);
   c_xfer: cover property (@(posedge sys_clk) rw_active && enc_valid);
endmodule // dds_sequencer

// ===== verif/dds_far_model.sv
/*
 Far-side model: controller board on the command/data bus, positioner,
 spindle pulses and the serial encoder sink.
 Assumes it shares sys_clk and rst with the sequencer.
*/
module dds_far_model
   import dds_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] seek_mode,
   input wire logic seek_dir,
   input wire logic ctrl_irq,
   input wire logic rw_active,
   input wire logic ctrl_byte_ready,
   input wire logic enc_valid,
   input wire logic [7:0] enc_data,
   output logic [10:0] head_position = 11'h000,
   output logic track_cross = 1'b0,
   output logic quarter_track = 1'b0,
   output logic sector_pulse = 1'b0,
   output logic index_pulse = 1'b0,
   output logic bus_data_mode = 1'b0,
   output logic ctrl_byte_valid = 1'b0,
   output logic [7:0] ctrl_byte = 8'h00,
   output logic enc_ready = 1'b0,
   output logic [9:0] enc_count = 10'h000,
   output logic enc_err = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] q = 3'h0;
   logic [9:0] tick = 10'h000;
   logic [9:0] sent = 10'h000;
   logic moving;
   assign moving = (seek_mode != DDS_TRACK_FOLLOW);
   // ****************
   // Positioner and spindle
   // ****************
   // Track every 8 cycles keeps the all-track seek test short
   always @(posedge sys_clk)
   begin
      q <= moving ? q + 3'h1 : 3'h0;
      quarter_track <= moving && q[0];
      track_cross <= moving && (q == 3'h7);
      tick <= rst ? 10'h000 : tick + 10'h001;
      sector_pulse <= (tick[3:0] == 4'hF);
      index_pulse <= (tick == 10'h3F7);
      enc_ready <= (tick[1:0] != 2'h0);
      if (rst)
         head_position <= 11'h000;
      else if (moving && (q == 3'h7))
         head_position <= seek_dir ? head_position + 11'h001
            : head_position - 11'h001;
   end
   // ****************
   // Controller and encoder sink
   // ****************
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         bus_data_mode <= 1'b0;
         ctrl_byte_valid <= 1'b0;
         sent <= 10'h000;
         enc_count <= 10'h000;
      end
      else if (ctrl_irq && !bus_data_mode && sent == 10'h000)
         bus_data_mode <= 1'b1;
      else if (ctrl_byte_valid && ctrl_byte_ready)
      begin
         sent <= sent + 10'h001;
         ctrl_byte_valid <= (sent != 10'h20A);
         // Released bus shows the inverse, not a stale byte
         ctrl_byte <= (sent == 10'h20A) ? ~ctrl_byte : ctrl_byte + 8'h01;
      end
      // Headers always match here, so no sector is skipped
      else if (rw_active && bus_data_mode && sent != 10'h20B)
         ctrl_byte_valid <= 1'b1;
      else if (sent == 10'h20B && enc_count == 10'h20B)
         bus_data_mode <= 1'b0;
      if (!rst && enc_valid && enc_ready)
      begin
         enc_count <= enc_count + 10'h001;
         enc_err <= enc_err || (enc_data !== enc_count[7:0]);
      end
   end
endmodule // dds_far_model

// ===== verif/tb_top.sv
/*
 Testbench of the operation sequencer: power-on, self-test, seek and
 write start. Assumes dds_far_model stands on the far side.
*/
`include "dds_regs.svh"
module tb_top
   import dds_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Short power-on count keeps the run brief
   localparam int PON = 20;
   logic sys_clk, rst, power_switch, supply_fault, test_fail;
   logic power_on_pulse, power_down, hard_reset, servo_disable;
   logic write_protect, ready_led, track_cross, quarter_track, pos_check;
   logic seek_done, seek_dir, sector_pulse, index_pulse, ctrl_irq;
   logic bus_data_mode, rw_ctrl_write, rw_active, ctrl_byte_valid;
   logic ctrl_byte_ready, enc_valid, enc_ready, enc_err;
   logic avs_read, avs_write, avs_waitrequest;
   logic [1:0] seek_mode, last_mode;
   logic [3:0] display_code, head_select, avs_address;
   logic [7:0] ctrl_byte, enc_data;
   logic [9:0] enc_count;
   logic [10:0] head_position, remaining_track_count;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] disp_log [$];
   logic [3:0] exp_disp [7] = '{4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1,
      `DDS_DISP_BLANK};
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   int w;
   int n;

   always #10 sys_clk = ~sys_clk;

   dds_sequencer #(.PON_CYCLES(PON)) u_dut
   (
      .sys_clk, .rst, .power_switch, .supply_fault, .power_on_pulse,
      .power_down, .hard_reset, .servo_disable, .write_protect,
      .display_code, .ready_led, .track_cross, .quarter_track,
      .head_position, .test_fail, .seek_mode, .seek_dir,
      .remaining_track_count, .pos_check, .seek_done, .sector_pulse,
      .index_pulse, .head_select, .ctrl_irq, .bus_data_mode,
      .rw_ctrl_write, .rw_active, .ctrl_byte_valid, .ctrl_byte,
      .ctrl_byte_ready, .enc_valid, .enc_data, .enc_ready, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest
   );

   dds_far_model u_far
   (
      .sys_clk, .rst, .seek_mode, .seek_dir, .ctrl_irq, .rw_active,
      .ctrl_byte_ready, .enc_valid, .enc_data, .head_position,
      .track_cross, .quarter_track, .sector_pulse, .index_pulse,
      .bus_data_mode, .ctrl_byte_valid, .ctrl_byte, .enc_ready,
      .enc_count, .enc_err
   );
   // ****************
   // Checking and bus tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Entered just after an edge; one spare edge avoids a double drive
   task automatic xfer(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // ****************
   // Watchdog and monitors
   // ****************
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      last_mode <= seek_mode;
      if (cycles == 95000)
      begin
         n_mismatch++;
         report_and_stop();
      end
      if (hard_reset === 1'b1)
      begin
         check(servo_disable, 1'b1);
         check(write_protect, 1'b1);
      end
      if (seek_mode === DDS_FINE && last_mode === DDS_COARSE)
         check(remaining_track_count, 11'h001);
      if (seek_mode === DDS_FINE)
         check(pos_check, 1'b1);
      if (seek_mode === DDS_COARSE)
         check(pos_check, quarter_track);
      if (rw_ctrl_write === 1'b1)
         check(bus_data_mode, 1'b1);
   end
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      sys_clk = 1'b0;
      rst = 1'b1;
      power_switch = 1'b0;
      supply_fault = 1'b0;
      test_fail = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge sys_clk);
      check(hard_reset, 1'b1);
      rst <= 1'b0;
      supply_fault <= 1'b1;
      power_switch <= 1'b1;
      for (w = 0; w < 50 && power_on_pulse !== 1'b1; w++)
         @(posedge sys_clk);
      for (n = 0; n < 100 && power_on_pulse === 1'b1; n++)
      begin
         check(hard_reset, 1'b1);
         @(posedge sys_clk);
      end
      check(n, PON);
      repeat (3) @(posedge sys_clk);
      check(power_down, 1'b1);
      check(hard_reset, 1'b1);
      // Power cycle without reset: only the pulse may clear the latch
      power_switch <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check(power_down, 1'b0);
      power_switch <= 1'b1;
      supply_fault <= 1'b0;
      for (w = 0; w < PON + 50 && hard_reset !== 1'b0; w++)
         @(posedge sys_clk);
      check(hard_reset, 1'b0);
      for (w = 0; w < 80000; w++)
      begin
         if (disp_log.size() == 0 || disp_log[$] !== display_code)
            disp_log.push_back(display_code);
         if (ready_led === 1'b1)
            break;
         @(posedge sys_clk);
      end
      check(disp_log.size(), 7);
      foreach (exp_disp[i])
         check(disp_log[i], exp_disp[i]);
      check(ready_led, 1'b1);
      check(head_position, `DDS_TEST_CYL);
      check(servo_disable, 1'b0);
      xfer(1'b0, `DDS_OFS_STATUS, 32'h0);
      check(q[11], 1'b1);
      check(q[10], 1'b0);
      xfer(1'b0, 4'hF, 32'h0);
      check(q, 32'h0);
      xfer(1'b0, `DDS_OFS_TRACK, 32'h0);
      check(q[10:0], `DDS_TEST_CYL);
      // Seek inward from the test cylinder to cylinder 100
      xfer(1'b1, `DDS_OFS_PACKET, 32'h0054_A064);
      xfer(1'b1, `DDS_OFS_CMD, {29'h0, `DDS_CMD_SEEK});
      for (w = 0; w < 50 && seek_mode !== DDS_COARSE; w++)
         @(posedge sys_clk);
      check(seek_dir, 1'b0);
      check(remaining_track_count, `DDS_TEST_CYL - 11'h064);
      for (w = 0; w < 9000 && seek_done !== 1'b1; w++)
         @(posedge sys_clk);
      check(head_position, 11'h064);
      @(posedge sys_clk);
      check(seek_mode, DDS_TRACK_FOLLOW);
      // Write: head 7, sector 20, cylinder 50, offset 2
      xfer(1'b1, `DDS_OFS_OFFSET, 32'h2);
      xfer(1'b1, `DDS_OFS_PACKET, 32'h00DD_4032);
      xfer(1'b1, `DDS_OFS_CMD, {29'h0, `DDS_CMD_WRITE});
      for (w = 0; w < 5000 && ctrl_irq !== 1'b1; w++)
         @(posedge sys_clk);
      check(head_select, 4'h7);
      check(rw_active, 1'b0);
      for (w = 0; w < 5000 && enc_count !== `DDS_SECTOR_BYTES; w++)
         @(posedge sys_clk);
      check(enc_count, `DDS_SECTOR_BYTES);
      check(enc_err, 1'b0);
      for (w = 0; w < 50 && rw_active !== 1'b0; w++)
         @(posedge sys_clk);
      check(rw_active, 1'b0);
      check(write_protect, 1'b1);
      xfer(1'b1, `DDS_OFS_CMD, {29'h0, `DDS_CMD_SELFTEST});
      for (w = 0; w < 50 && display_code !== 4'h6; w++)
         @(posedge sys_clk);
      check(display_code, 4'h6);
      check(ready_led, 1'b0);
      report_and_stop();
   end
endmodule // tb_top
